// ### led_fault_powersave_ctrl_regs.vh
// What this block does
// - open-lamp flag set when pin below threshold
// - threshold chosen by field in control word one
// - flag sampled only in channel on phase
// - flag forced zero for channels turned off
// - suppress enable is word one bit four
// - suppressed open channel latched off until reset
// - power save enable is word two bit five
// - all-zero next frame enters power save at once
// - any nonzero grayscale word leaves power save
// - power save disables outputs and open detection
// - pre-charge pull-up during common line switching
// - over-temperature turns every output off
// - reference short turns every output off
// - three nine-bit color scales reset to 100h
// - global gain code resets to 4h
// - global gain change acts immediately
`ifndef LED_FAULT_POWERSAVE_CTRL_REGS_VH
`define LED_FAULT_POWERSAVE_CTRL_REGS_VH

// sizes
`define NCH          48
`define GS_W         16
`define ADDR_W       5
`define THR_W        2

// register byte offsets
`define OFF_FC1_LO   5'h00
`define OFF_FC1_HI   5'h04
`define OFF_FC2      5'h08
`define OFF_FLAG_LO  5'h0c
`define OFF_FLAG_HI  5'h10
`define OFF_LOCK_LO  5'h14
`define OFF_LOCK_HI  5'h18
`define OFF_STATUS   5'h1c

// reset values and writable bits
`define FC1LO_RST    32'h00000080
`define FC1LO_WMASK  32'h000000f3
`define FC1HI_RST    32'h04020100
`define FC1HI_WMASK  32'h07ffffff
`define FC2_RST      32'h00000000
`define FC2_WMASK    32'h00000020

// field positions in word one, low half
`define THR_LSB      0
`define THR_MSB      1
`define SUPPRESS_BIT 4
`define GAIN_LSB     5
`define GAIN_MSB     7
// field positions in word one, high half
`define RED_LSB      0
`define RED_MSB      8
`define GRN_LSB      9
`define GRN_MSB      17
`define BLU_LSB      18
`define BLU_MSB      26
// field position in word two
`define PSAVE_BIT    5
// status word bits
`define ST_SAVE_BIT  0
`define ST_OT_BIT    1
`define ST_RS_BIT    2
`define ST_SHUT_BIT  3

`endif

// ### sync_agree.v
module sync_agree #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             clock_i,
  input  wire             nrst_i,
  // asynchronous level in, clean level out
  input  wire [WIDTH-1:0] async_i,
  output reg  [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] stage1; // metastability catcher, read by stage2 only
  reg [WIDTH-1:0] stage2; // second stage
  reg [WIDTH-1:0] stage3; // third stage, agreement check

  // three stage flops and an output flop; a bit moves only when stages two and three agree
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stage1 <= {WIDTH{1'b0}};
      stage2 <= {WIDTH{1'b0}};
      stage3 <= {WIDTH{1'b0}};
      sync_o <= {WIDTH{1'b0}};
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
      stage3 <= stage2;
      // filters single-cycle glitches at the cost of one cycle
      sync_o <= (stage3 & ~(stage2 ^ stage3)) | (sync_o & (stage2 ^ stage3));
    end
  end

endmodule

// ### open_lamp_channel.v
module open_lamp_channel (
  // clock and reset
  input  wire clock_i,
  input  wire nrst_i,
  // channel inputs
  input  wire below_i,
  input  wire on_i,
  input  wire detect_active_i,
  input  wire suppress_en_i,
  input  wire shutdown_i,
  // channel outputs
  output reg  flag_o,
  output reg  locked_o,
  output reg  drive_o
);

  // flag, suppression latch and output drive of one sink
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flag_o   <= 1'b0;
      locked_o <= 1'b0;
      drive_o  <= 1'b0;
    end else begin
      // off channel reads zero; off-phase samples are dropped
      flag_o   <= on_i & detect_active_i & below_i;
      // latch never clears; only reset frees the channel
      locked_o <= locked_o | (suppress_en_i & flag_o);
      // any global fault or power save kills the drive
      drive_o  <= on_i & detect_active_i & ~shutdown_i & ~locked_o;
    end
  end

endmodule

// ### led_fault_powersave_ctrl.v
// Local design decisions: the register offsets and the Avalon-MM slave port.
`include "led_fault_powersave_ctrl_regs.vh"

module led_fault_powersave_ctrl (
  // clock and reset
  input  wire                 clock_i,
  input  wire                 nrst_i,
  // avalon-mm slave
  input  wire [`ADDR_W-1:0]   address_i,
  input  wire                 read_i,
  input  wire                 write_i,
  input  wire [3:0]           byteenable_i,
  input  wire [31:0]          writedata_i,
  output wire [31:0]          readdata_o,
  output wire                 waitrequest_o,
  // analog indications, asynchronous
  input  wire                 over_temp_shutdown_i,
  input  wire                 ref_short_guard_i,
  input  wire [`NCH-1:0]      below_threshold_i,
  // pwm and scan timing, same clock
  input  wire [`NCH-1:0]      channel_on_i,
  input  wire                 common_switch_i,
  // grayscale stream for the next frame, same clock
  input  wire                 gs_frame_start_i,
  input  wire                 gs_word_valid_i,
  input  wire [`GS_W-1:0]     grayscale_value_i,
  input  wire                 gs_frame_end_i,
  // analog controls
  output wire [`NCH-1:0]      sink_output_o,
  output reg                  precharge_o,
  output reg                  analog_enable_o,
  output wire [`THR_W-1:0]    open_detect_threshold_sel_o,
  output wire [2:0]           global_gain_code_o,
  output wire [8:0]           red_group_scale_o,
  output wire [8:0]           green_group_scale_o,
  output wire [8:0]           blue_group_scale_o,
  // state view
  output wire [`NCH-1:0]      open_lamp_flag_o,
  output wire                 power_save_state_o
);

  // power-save states
  // one bit is enough: the block is either lit or saving
  localparam ST_NORMAL = 1'b0;
  localparam ST_SAVE   = 1'b1;

  // everything below runs on the one device clock
  // registers
  reg  [31:0]     fc1_lo;          // threshold, suppress enable, gain
  reg  [31:0]     fc1_hi;          // three color scale fields
  reg  [31:0]     fc2;             // power save enable
  reg             ack;             // one wait state per access
  reg  [31:0]     rdata;           // registered read data
  reg  [31:0]     next_rdata;      // read mux
  reg             state;           // power-save state
  reg             next_state;      // next power-save state
  reg             nonzero_seen;    // nonzero word seen this frame
  reg             next_nonzero;    // next value of it
  wire            ot_sync;         // clean over-temperature level
  wire            rs_sync;         // clean reference-short level
  wire [`NCH-1:0] below_sync;      // clean comparator levels
  wire [`NCH-1:0] locked;          // suppressed channels
  wire [31:0]     bmask;           // byte-lane write mask
  wire            wr_take;         // write takes effect this edge
  wire            shutdown;        // global output kill
  wire            detect_active;   // analog path alive
  wire            suppress_en;     // open-lamp suppression
  wire            power_save_en;   // power-save operation
  wire            gs_nonzero;      // incoming word is nonzero
  reg  [`NCH-1:0] on_d1;           // channel on, one edge back
  reg  [`NCH-1:0] on_d2;           // two edges back
  reg  [`NCH-1:0] on_d3;           // three edges back
  reg  [`NCH-1:0] on_d4;           // four edges back
  wire [`NCH-1:0] on_settled;      // lit through the comparator lag
  wire [`NCH-1:0] below_valid;     // comparator reading taken while lit

  // field views of the control words
  // the analog side reads these fields directly; nothing here
  // double-buffers them, so a write shows on the following edge
  assign open_detect_threshold_sel_o = fc1_lo[`THR_MSB:`THR_LSB];
  assign suppress_en        = fc1_lo[`SUPPRESS_BIT];
  // gain goes straight to the current dac, no frame wait
  assign global_gain_code_o  = fc1_lo[`GAIN_MSB:`GAIN_LSB];
  // colour scales act at once as well, like the gain
  assign red_group_scale_o   = fc1_hi[`RED_MSB:`RED_LSB];
  assign green_group_scale_o = fc1_hi[`GRN_MSB:`GRN_LSB];
  assign blue_group_scale_o  = fc1_hi[`BLU_MSB:`BLU_LSB];
  assign power_save_en      = fc2[`PSAVE_BIT];
  assign power_save_state_o = state;

  // bus handshake
  // exactly one wait state: waitrequest is low in the cycle after
  // a request is first seen, and a write lands at that edge
  assign waitrequest_o = ~ack;
  assign readdata_o    = rdata;
  assign wr_take       = write_i & ack;
  // write lanes follow byteenable; reads ignore it
  assign bmask = {{8{byteenable_i[3]}}, {8{byteenable_i[2]}},
                  {8{byteenable_i[1]}}, {8{byteenable_i[0]}}};

  // global kill and analog gating
  // either fault alone drops every sink; hysteresis is analog
  assign shutdown      = ot_sync | rs_sync;
  assign detect_active = (state == ST_NORMAL);
  // a word without its qualifier is never looked at
  assign gs_nonzero    = gs_word_valid_i & (grayscale_value_i != {`GS_W{1'b0}});

  // fault indications carry their own analog hysteresis
  // both faults share one synchroniser so their lag is equal
  sync_agree #(
    .WIDTH (2)
  ) u_fault_sync (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .async_i ({over_temp_shutdown_i, ref_short_guard_i}),
    .sync_o  ({ot_sync, rs_sync})
  );

  // comparators change with the pwm edges, so filter them too
  // wide, but cheap next to the analog sinks it guards
  sync_agree #(
    .WIDTH (`NCH)
  ) u_cmp_sync (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .async_i (below_threshold_i),
    .sync_o  (below_sync)
  );

  // channel on history, one stage per edge of comparator lag
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      // nothing counts as lit straight out of reset
      on_d1 <= {`NCH{1'b0}};
      on_d2 <= {`NCH{1'b0}};
      on_d3 <= {`NCH{1'b0}};
      on_d4 <= {`NCH{1'b0}};
    end else begin
      // same-clock level, so no synchroniser in front
      on_d1 <= channel_on_i;
      on_d2 <= on_d1;
      on_d3 <= on_d2;
      on_d4 <= on_d3;
    end
  end

  // the synchronised reading lags four edges, so the first edges of an
  // on phase still show what the pin did while it was off
  assign on_settled  = channel_on_i & on_d1 & on_d2 & on_d3 & on_d4;
  // off-phase readings are dropped before they reach a flag
  assign below_valid = below_sync & on_settled;

  // one flag, latch and drive cell per sink
  // the drive is itself a flop, so no glitch reaches a pin
  genvar ch;
  generate
    for (ch = 0; ch < `NCH; ch = ch + 1) begin : g_ch
      // cell index matches the bit index of every vector
      open_lamp_channel u_ch (
        .clock_i         (clock_i),
        .nrst_i          (nrst_i),
        .below_i         (below_valid[ch]),
        .on_i            (channel_on_i[ch]),
        .detect_active_i (detect_active),
        .suppress_en_i   (suppress_en),
        .shutdown_i      (shutdown),
        .flag_o          (open_lamp_flag_o[ch]),
        .locked_o        (locked[ch]),
        .drive_o         (sink_output_o[ch])
      );
    end
  endgenerate

  // bus acknowledge: request seen, answer one edge later
  // read and write are never high together, so one flag serves both
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      // idle: waitrequest stands high
      ack <= 1'b0;
    end else begin
      // drops after each answer so a held request is not doubled
      ack <= (read_i | write_i) & ~ack;
    end
  end

  // read mux; unmapped offsets read zero
  // unaligned addresses fall to the default and read zero
  always @* begin
    next_rdata = 32'h00000000;
    case (address_i)
      `OFF_FC1_LO:  next_rdata = fc1_lo;
      `OFF_FC1_HI:  next_rdata = fc1_hi;
      `OFF_FC2:     next_rdata = fc2;
      `OFF_FLAG_LO: next_rdata = open_lamp_flag_o[31:0];
      `OFF_FLAG_HI: next_rdata = {16'h0000, open_lamp_flag_o[`NCH-1:32]};
      // latch words show which sinks suppression has taken
      `OFF_LOCK_LO: next_rdata = locked[31:0];
      `OFF_LOCK_HI: next_rdata = {16'h0000, locked[`NCH-1:32]};
      `OFF_STATUS: begin
        // bits not listed stay zero from the default above
        // fault bits read back their synchronised levels
        next_rdata[`ST_SAVE_BIT] = state;
        next_rdata[`ST_OT_BIT]   = ot_sync;
        next_rdata[`ST_RS_BIT]   = rs_sync;
        next_rdata[`ST_SHUT_BIT] = shutdown;
      end
      default: next_rdata = 32'h00000000;
    endcase
  end

  // read data is loaded while waitrequest is still high
  // and then held, so readdata stays put until the next read
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata <= 32'h00000000;
    end else if (read_i & ~ack) begin
      rdata <= next_rdata;
    end
  end

  // control words; unwritable bits stay zero
  // byte lanes merge with the old contents
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fc1_lo <= `FC1LO_RST;
      fc1_hi <= `FC1HI_RST;
      fc2    <= `FC2_RST;
    end else if (wr_take) begin
      case (address_i)
        `OFF_FC1_LO: begin
          // threshold, suppress enable and gain
          fc1_lo <= (fc1_lo & ~bmask) | (writedata_i & bmask & `FC1LO_WMASK);
        end
        `OFF_FC1_HI: begin
          // red, green and blue scales
          fc1_hi <= (fc1_hi & ~bmask) | (writedata_i & bmask & `FC1HI_WMASK);
        end
        `OFF_FC2: begin
          // power-save enable only
          fc2 <= (fc2 & ~bmask) | (writedata_i & bmask & `FC2_WMASK);
        end
        default: begin
          // read-only or unmapped: ignored
        end
      endcase
    end
  end

  // power-save next state and frame content tracking
  // a frame that ends with no lit word puts the block to sleep;
  // the first lit word after that wakes it again
  always @* begin
    next_state   = state;
    next_nonzero = nonzero_seen;
    if (gs_frame_start_i) begin
      // a new frame starts clean
      next_nonzero = 1'b0;
    end
    if (gs_nonzero) begin
      // a lit word in the start cycle still counts
      next_nonzero = 1'b1;
    end
    // entries and exits are decided on the edge of the word itself
    case (state)
      ST_NORMAL: begin
        // stays lit while power save is disabled
        // the word in the end cycle counts toward the frame
        if (power_save_en & gs_frame_end_i & ~next_nonzero) begin
          next_state = ST_SAVE;
        end
      end
      ST_SAVE: begin
        // leave at the first nonzero word, or when disabled
        // clearing the enable is the software way out
        if (gs_nonzero | ~power_save_en) begin
          next_state = ST_NORMAL;
        end
      end
      default: next_state = ST_NORMAL;
    endcase
  end

  // power-save state, frame tracker and analog enables
  // analog enable is registered from the next state so that it
  // drops on the same edge as the state bit
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      // wake up lit, not saving
      state           <= ST_NORMAL;
      nonzero_seen    <= 1'b0;
      analog_enable_o <= 1'b1;
      precharge_o     <= 1'b0;
    end else begin
      // frame tracker runs in both states
      state           <= next_state;
      nonzero_seen    <= next_nonzero;
      // current sinks and detectors off while saving
      analog_enable_o <= (next_state == ST_NORMAL);
      // pull outputs up while the common line changes over
      // not gated by power save: the pull-up costs little
      precharge_o     <= common_switch_i;
    end
  end

endmodule

// ### led_fault_powersave_ctrl_monitor.sv
`include "led_fault_powersave_ctrl_regs.vh"

module led_fault_powersave_ctrl_monitor (
  // clock and reset
  input logic               clock_i,
  input logic               nrst_i,
  // register bus
  input logic [`ADDR_W-1:0] address_i,
  input logic               write_i,
  input logic [3:0]         byteenable_i,
  input logic [31:0]        writedata_i,
  input logic               waitrequest_o,
  // faults, timing, grayscale
  input logic               over_temp_shutdown_i,
  input logic               ref_short_guard_i,
  input logic [`NCH-1:0]    channel_on_i,
  input logic               common_switch_i,
  input logic               gs_word_valid_i,
  input logic [`GS_W-1:0]   grayscale_value_i,
  // controls and state
  input logic [`NCH-1:0]    sink_output_o,
  input logic               precharge_o,
  input logic               analog_enable_o,
  input logic [2:0]         global_gain_code_o,
  input logic [`NCH-1:0]    open_lamp_flag_o,
  input logic               power_save_state_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // a flag may only stand for a channel that was on
  flag_off_a: assert property ((open_lamp_flag_o & ~$past(channel_on_i)) == '0)
    else $error("open flag on an idle channel");
  // no drive and no flags once power save has settled
  ps_quiet_a: assert property (power_save_state_o && $past(power_save_state_o)
    |-> sink_output_o == '0 && open_lamp_flag_o == '0) else $error("active in power save");
  ps_analog_a: assert property (analog_enable_o != power_save_state_o)
    else $error("analog enable disagrees with power save");
  // any lit grayscale word wakes the block up
  ps_exit_a: assert property (gs_word_valid_i && grayscale_value_i != '0
    |=> !power_save_state_o) else $error("power save kept after lit word");
  // seven samples cover the synchroniser plus the output flop
  hot_off_a: assert property (over_temp_shutdown_i [*7] |-> sink_output_o == '0)
    else $error("outputs driven while hot");
  short_off_a: assert property (ref_short_guard_i [*7] |-> sink_output_o == '0)
    else $error("outputs driven with shorted reference");
  pre_follow_a: assert property (precharge_o == $past(common_switch_i))
    else $error("precharge does not follow common switch");
  gain_now_a: assert property (write_i && !waitrequest_o && address_i == `OFF_FC1_LO
    && byteenable_i[0] |=> global_gain_code_o == $past(writedata_i[7:5]))
    else $error("gain write not applied at once");
  cover property (power_save_state_o);
  cover property (open_lamp_flag_o != '0);
  cover property (precharge_o);
endmodule

bind led_fault_powersave_ctrl led_fault_powersave_ctrl_monitor u_mon (.clock_i, .nrst_i,
  .address_i, .write_i, .byteenable_i, .writedata_i, .waitrequest_o, .over_temp_shutdown_i,
  .ref_short_guard_i, .channel_on_i, .common_switch_i, .gs_word_valid_i, .grayscale_value_i,
  .sink_output_o, .precharge_o, .analog_enable_o, .global_gain_code_o, .open_lamp_flag_o,
  .power_save_state_o);

// ### gs_frame_source.sv
module gs_frame_source (
  // clock and command
  input  wire        clock_i,
  input  wire        go_i,
  input  wire        lit_i,
  // grayscale stream
  output reg         gs_frame_start_o = 1'b0,
  output reg         gs_word_valid_o = 1'b0,
  output reg  [15:0] grayscale_value_o = 16'h0000,
  output reg         gs_frame_end_o = 1'b0,
  output wire        busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [2:0] step = 3'd0; // 0 idle, 1..4 words
  assign busy_o = step != 3'd0;
  // start pulse, four words, end pulse with the last word
  always @(posedge clock_i) begin
    gs_frame_start_o <= 1'b0;
    gs_word_valid_o <= 1'b0;
    gs_frame_end_o <= 1'b0;
    // unqualified data keeps moving, never a stale copy
    grayscale_value_o <= ~grayscale_value_o;
    if (step == 3'd0 && go_i) begin
      gs_frame_start_o <= 1'b1;
      step <= 3'd1;
    end else if (step != 3'd0) begin
      gs_word_valid_o <= 1'b1;
      grayscale_value_o <= (lit_i && step == 3'd2) ? 16'h0001 : 16'h0000;
      gs_frame_end_o <= step == 3'd4;
      step <= (step == 3'd4) ? 3'd0 : step + 3'd1;
    end
  end
endmodule

// ### test_led_fault_powersave_ctrl.sv
`include "led_fault_powersave_ctrl_regs.vh"

module test_led_fault_powersave_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  // bench drives
  logic        clock_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [4:0]  address_i = 5'h00;
  logic        read_i = 1'b0;
  logic        write_i = 1'b0;
  logic [3:0]  byteenable_i = 4'hf;
  logic [31:0] writedata_i = 32'h0;
  logic        over_temp_shutdown_i = 1'b0;
  logic        ref_short_guard_i = 1'b0;
  logic [47:0] below_threshold_i = 48'h0;
  logic [47:0] channel_on_i = 48'h0;
  logic        common_switch_i = 1'b0;
  logic        go = 1'b0;
  logic        lit = 1'b0;
  // design and partner outputs
  wire [31:0]  readdata_o;
  wire         waitrequest_o, gs_frame_start_i, gs_word_valid_i, gs_frame_end_i, busy;
  wire [15:0]  grayscale_value_i;
  wire [47:0]  sink_output_o, open_lamp_flag_o;
  wire         precharge_o, analog_enable_o, power_save_state_o;
  wire [1:0]   thr;
  wire [2:0]   gain;
  wire [8:0]   red, green, blue;
  integer      failures = 0, compares = 0, cycles = 0;
  logic [31:0] rd;

  led_fault_powersave_ctrl DUT (.clock_i, .nrst_i, .address_i, .read_i, .write_i,
    .byteenable_i, .writedata_i, .readdata_o, .waitrequest_o, .over_temp_shutdown_i,
    .ref_short_guard_i, .below_threshold_i, .channel_on_i, .common_switch_i,
    .gs_frame_start_i, .gs_word_valid_i, .grayscale_value_i, .gs_frame_end_i,
    .sink_output_o, .precharge_o, .analog_enable_o, .open_detect_threshold_sel_o(thr),
    .global_gain_code_o(gain), .red_group_scale_o(red), .green_group_scale_o(green),
    .blue_group_scale_o(blue), .open_lamp_flag_o, .power_save_state_o);
  gs_frame_source far_side (.clock_i, .go_i(go), .lit_i(lit),
    .gs_frame_start_o(gs_frame_start_i), .gs_word_valid_o(gs_word_valid_i),
    .grayscale_value_o(grayscale_value_i), .gs_frame_end_o(gs_frame_end_i), .busy_o(busy));

  initial begin
    forever #5 clock_i = ~clock_i;
  end

  task chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  // one bus cycle held until waitrequest is sampled low, one idle edge after
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
    address_i <= a;
    writedata_i <= wd;
    write_i <= wr;
    read_i <= !wr;
    @(posedge clock_i);
    while (waitrequest_o !== 1'b0) @(posedge clock_i);
    rd = readdata_o;
    write_i <= 1'b0;
    read_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task rd_chk(input logic [4:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask
  task frame(input logic nz);
    lit <= nz;
    go <= 1'b1;
    cyc(1);
    go <= 1'b0;
    cyc(1);
    while (busy) cyc(1);
    cyc(3);
  endtask

  task t_reset;
    chk("gain", gain, 3'h4);
    chk("scales", {red, green, blue}, {9'h100, 9'h100, 9'h100});
    rd_chk(`OFF_FC1_LO, 32'h80, "word one low");
    rd_chk(`OFF_FC1_HI, 32'h04020100, "word one high");
    rd_chk(`OFF_FC2, 32'h0, "word two");
    rd_chk(5'h03, 32'h0, "unmapped");
  endtask
  task t_gain;
    bus(1'b1, `OFF_FC1_LO, 32'he2);
    chk("gain", gain, 3'h7);
    chk("threshold", thr, 2'h2);
    bus(1'b1, `OFF_FC1_HI, 32'h033267ff);
    chk("scales", {red, green, blue}, {9'h1ff, 9'h133, 9'h0cc});
    // one lane only: the top bit of red and the low seven bits of green
    byteenable_i <= 4'h2;
    bus(1'b1, `OFF_FC1_HI, 32'h0);
    byteenable_i <= 4'hf;
    chk("lane write", {red, green, blue}, {9'h0ff, 9'h100, 9'h0cc});
    bus(1'b1, `OFF_STATUS, 32'hf);
    rd_chk(`OFF_STATUS, 32'h0, "status");
  endtask
  task t_open;
    channel_on_i <= 48'h408;
    below_threshold_i <= 48'h28;
    cyc(8);
    chk("flags", open_lamp_flag_o, 48'h8);
    chk("sinks", sink_output_o, 48'h408);
    rd_chk(`OFF_FLAG_LO, 32'h8, "flag word");
    common_switch_i <= 1'b1;
    cyc(2);
    chk("precharge", precharge_o, 1'b1);
    common_switch_i <= 1'b0;
    cyc(2);
    chk("precharge off", precharge_o, 1'b0);
    channel_on_i <= 48'h400;
    cyc(3);
    chk("flags", open_lamp_flag_o, 48'h0);
    bus(1'b1, `OFF_FC1_LO, 32'h92);
    chk("mid gain", gain, 3'h4);
    channel_on_i <= 48'h408;
    cyc(8);
    below_threshold_i <= 48'h0;
    cyc(8);
    chk("locked sinks", sink_output_o, 48'h400);
    rd_chk(`OFF_LOCK_LO, 32'h8, "lock word");
  endtask
  task t_fault(input logic rs);
    if (rs) ref_short_guard_i <= 1'b1;
    else over_temp_shutdown_i <= 1'b1;
    cyc(8);
    chk("fault sinks", sink_output_o, 48'h0);
    rd_chk(`OFF_STATUS, rs ? 32'hc : 32'ha, "status");
    ref_short_guard_i <= 1'b0;
    over_temp_shutdown_i <= 1'b0;
    cyc(8);
    chk("resumed sinks", sink_output_o, 48'h400);
  endtask
  task t_psave;
    bus(1'b1, `OFF_FC2, 32'h20);
    rd_chk(`OFF_FC2, 32'h20, "word two");
    frame(1'b0);
    chk("save state", power_save_state_o, 1'b1);
    chk("analog", {analog_enable_o, sink_output_o}, 49'h0);
    frame(1'b1);
    chk("save state", power_save_state_o, 1'b0);
    chk("sinks", sink_output_o, 48'h400);
    chk("analog on", analog_enable_o, 1'b1);
    frame(1'b0);
    chk("save again", power_save_state_o, 1'b1);
    bus(1'b1, `OFF_FC2, 32'h0);
    cyc(1);
    chk("save off", power_save_state_o, 1'b0);
  endtask

  task report_and_stop;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // hang guard, far above the 150 or so cycles needed
  always @(posedge clock_i) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      failures = failures + 1;
      report_and_stop;
    end
  end

  initial begin
    repeat (4) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(posedge clock_i);
    t_reset;
    t_gain;
    t_open;
    t_fault(1'b0);
    t_fault(1'b1);
    t_psave;
    report_and_stop;
  end
endmodule
